// file: design/srw_pkg.sv
package srw_pkg;
    // reference position map
    localparam int MAP_BITS = 16;
    localparam int MAP_LO = 0;
    localparam int MAP_HI = 15;
    localparam logic [MAP_BITS-1:0] MAP_RESET = 16'h8001;
    localparam int SEL_W = 4;
    // system divider: eight converter clocks per bus times buses per channel
    localparam int SYS_DIV_BASE = 8;
    localparam int BUSES_PER_CH = 1;
    localparam int SYS_DIV = SYS_DIV_BASE * BUSES_PER_CH;
    localparam int SYS_CNT_W = 8;
    // trigger divider
    localparam int TRIGGER_DIVIDE_SETTING_W = 8;
    localparam logic [TRIGGER_DIVIDE_SETTING_W-1:0] TRIGGER_DIVIDE_SETTING_RESET = 8'h08;
    // realignment confirmation count on a new location
    localparam logic [1:0] REALIGN_PULSES = 2'h2;
    // alarm vector bit positions
    localparam int ALM_W = 3;
    localparam int ALM_CLK_REALIGNED = 0;
    localparam int ALM_TRIG_REALIGNED = 1;
    localparam int ALM_CLK_ALIGNMENT = 2;
    // data-clock strobe
    localparam int LANE_TOP = 12;
    localparam int NUM_BUSES = 4;
    localparam int WPTR_W = 4;
    localparam int TONE_W = 4;

    typedef struct packed {
        logic bank;
        logic [TONE_W-1:0] sel;
    } srw_tone_t;

    typedef struct packed {
        logic ref_receiver_sleep;
        logic ref_processing_enable;
        logic ref_step_fine;
        logic ref_map_persistence;
        logic [SEL_W-1:0] pos_select;
    } srw_ref_cfg_t;

    typedef struct packed {
        logic [TRIGGER_DIVIDE_SETTING_W-1:0] trigger_divide_setting;
        logic trigger_output_enable;
        logic oscillator_run_enable;
    } srw_trig_cfg_t;
endpackage : srw_pkg

// file: design/srw_sync2.sv
`timescale 1ns/1ps
module srw_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1_r;
        logic [W-1:0] s2_r;
    } srw_sync_st_t;

    srw_sync_st_t st_r;
    srw_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1_r = d;
        st_nxt.s2_r = st_r.s1_r;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2_r;
endmodule : srw_sync2

// file: design/srw_bus_strobe.sv
`timescale 1ns/1ps
module srw_bus_strobe
    import srw_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic use_lsb_strobe,
    input wire logic [3:0] input_width,
    input wire logic bus_strobe_input,
    input wire logic [DATA_W-1:0] bus_data,
    output logic strobe_seen,
    output logic [WPTR_W-1:0] write_ptr
);
    typedef struct packed {
        logic strobe_r;
        logic [WPTR_W-1:0] wptr_r;
    } srw_strobe_st_t;

    srw_strobe_st_t st_r;
    srw_strobe_st_t st_nxt;
    logic lane_bit;
    logic [3:0] lane_idx;

    assign lane_idx = 4'(LANE_TOP) - input_width;
    assign lane_bit = (lane_idx < 4'(DATA_W)) ? bus_data[lane_idx] : 1'b0;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.strobe_r = use_lsb_strobe ? lane_bit : bus_strobe_input;
        if (st_nxt.strobe_r)
            st_nxt.wptr_r = '0;
        else
            st_nxt.wptr_r = st_r.wptr_r + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign strobe_seen = st_r.strobe_r;
    assign write_ptr = st_r.wptr_r;
endmodule : srw_bus_strobe

// file: design/srw_sysref_window.sv
`timescale 1ns/1ps
module srw_sysref_window
    import srw_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ref_pulse_in,
    input wire logic [MAP_BITS-1:0] ref_phase_taps,
    input wire srw_pkg::srw_ref_cfg_t ref_cfg,
    input wire srw_pkg::srw_trig_cfg_t trig_cfg,
    input wire logic ref_align_enable,
    input wire logic [srw_pkg::ALM_W-1:0] fault_mask_register,
    input wire logic [srw_pkg::ALM_W-1:0] fault_clear,
    input wire logic mute_on_fault,
    input wire srw_pkg::srw_tone_t tone_pins,
    input wire logic use_lsb_strobe,
    input wire logic [3:0] input_width,
    input wire logic [srw_pkg::NUM_BUSES-1:0] bus_strobe_input,
    input wire logic [srw_pkg::NUM_BUSES*DATA_W-1:0] bus_data,
    output logic [srw_pkg::MAP_BITS-1:0] ref_position_map,
    output logic [srw_pkg::ALM_W-1:0] system_fault_register,
    output logic fault_pin,
    output logic output_mute,
    output logic trigger_clock_out,
    output logic read_ptr_reset,
    output srw_pkg::srw_tone_t tone_ch_a,
    output srw_pkg::srw_tone_t tone_ch_b,
    output logic [srw_pkg::NUM_BUSES-1:0] bus_strobe_seen,
    output logic [srw_pkg::NUM_BUSES*srw_pkg::WPTR_W-1:0] bus_write_ptr
);
    import srw_pkg::*;

    typedef struct packed {
        logic ref_d_r;
        logic ps_en_d_r;
        logic [MAP_BITS-1:0] map_r;
        logic [SYS_CNT_W-1:0] sys_cnt_r;
        logic [TRIGGER_DIVIDE_SETTING_W-1:0] trig_cnt_r;
        logic trig_clk_r;
        logic trig_out_r;
        logic [SYS_CNT_W-1:0] last_loc_r;
        logic [1:0] same_loc_r;
        logic [ALM_W-1:0] alm_r;
        logic fault_r;
        logic mute_r;
        logic rptr_rst_r;
        srw_tone_t tone_s_r;
        srw_tone_t tone_a_r;
        srw_tone_t tone_b_r;
        logic tone_pend_r;
    } srw_state_t;

    srw_state_t st_r;
    srw_state_t st_nxt;
    logic ref_s;
    logic [MAP_BITS-1:0] taps_s;
    srw_tone_t tone_s;
    logic ref_rise;
    logic [MAP_BITS-1:0] edge_map;
    logic [TRIGGER_DIVIDE_SETTING_W-1:0] div_eff;
    logic [TRIGGER_DIVIDE_SETTING_W-1:0] trig_last;
    logic [ALM_W-1:0] alm_set;
    // last count of the free-running system divider
    localparam logic [SYS_CNT_W-1:0] SYS_LAST = SYS_CNT_W'(SYS_DIV - 1);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    srw_sync2 #(.W(1)) u_ref_sync (
        .clk(clk),
        .reset(reset),
        .d(ref_pulse_in),
        .q(ref_s)
    );

    srw_sync2 #(.W(MAP_BITS)) u_tap_sync (
        .clk(clk),
        .reset(reset),
        .d(ref_phase_taps),
        .q(taps_s)
    );

    srw_sync2 #(.W(TONE_W + 1)) u_tone_sync (
        .clk(clk),
        .reset(reset),
        .d(tone_pins),
        .q(tone_s)
    );

    // ----------------------------------------------------------------
    // data-clock strobes
    // ----------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < NUM_BUSES; gb++)
        begin : g_bus
            srw_bus_strobe #(.DATA_W(DATA_W)) u_strobe (
                .clk(clk),
                .reset(reset),
                .use_lsb_strobe(use_lsb_strobe),
                .input_width(input_width),
                .bus_strobe_input(bus_strobe_input[gb]),
                .bus_data(bus_data[gb*DATA_W +: DATA_W]),
                .strobe_seen(bus_strobe_seen[gb]),
                .write_ptr(bus_write_ptr[gb*WPTR_W +: WPTR_W])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // helper decodes
    // ----------------------------------------------------------------
    function automatic logic [MAP_BITS-1:0] build_map(input logic [MAP_BITS-1:0] taps, input logic fine);
        logic [MAP_BITS-1:0] m;
        m = '0;
        // fine uses neighbour, coarse spans two steps
        for (int i = 1; i < MAP_BITS - 1; i++)
        begin
            if (fine)
                m[i] = taps[i] ^ taps[i-1];
            else
                m[i] = taps[i] ^ taps[(i >= 2) ? i - 2 : 0];
        end
        m[MAP_LO] = 1'b1;
        m[MAP_HI] = 1'b1;
        return m;
    endfunction : build_map

    assign ref_rise = ref_cfg.ref_processing_enable & ~ref_cfg.ref_receiver_sleep
        & ref_s & ~st_r.ref_d_r;
    assign edge_map = build_map(taps_s, ref_cfg.ref_step_fine);
    assign div_eff = (trig_cfg.trigger_divide_setting == '0) ? 8'h01 : trig_cfg.trigger_divide_setting;
    // last count before the trigger divider wraps
    assign trig_last = div_eff - 8'h01;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        alm_set = '0;
        st_nxt.ref_d_r = ref_s;
        st_nxt.ps_en_d_r = ref_cfg.ref_map_persistence;
        st_nxt.rptr_rst_r = 1'b0;
        st_nxt.tone_pend_r = 1'b0;

        // ------------------------------------------------------------
        // position map
        // ------------------------------------------------------------
        // persistence restart on rising enable
        if (ref_cfg.ref_map_persistence && !st_r.ps_en_d_r)
            st_nxt.map_r = MAP_RESET;
        if (ref_rise)
        begin
            if (ref_cfg.ref_map_persistence)
                st_nxt.map_r = st_nxt.map_r | edge_map;
            else
                st_nxt.map_r = edge_map;
        end

        // ------------------------------------------------------------
        // dividers
        // ------------------------------------------------------------
        // system divider free-runs
        if (st_r.sys_cnt_r == SYS_LAST)
            st_nxt.sys_cnt_r = '0;
        else
            st_nxt.sys_cnt_r = st_r.sys_cnt_r + 8'h01;

        // trigger divider
        if (st_r.trig_cnt_r >= trig_last)
            st_nxt.trig_cnt_r = '0;
        else
            st_nxt.trig_cnt_r = st_r.trig_cnt_r + 8'h01;
        // trigger clock low for the first half of its period
        st_nxt.trig_clk_r = (st_nxt.trig_cnt_r < (div_eff >> 1)) ? 1'b0 : 1'b1;

        // ------------------------------------------------------------
        // realignment on a reference edge
        // ------------------------------------------------------------
        if (ref_rise)
        begin
            if (st_r.sys_cnt_r == st_r.last_loc_r)
                st_nxt.same_loc_r = (st_r.same_loc_r == REALIGN_PULSES) ? REALIGN_PULSES : st_r.same_loc_r + 2'h1;
            else
                st_nxt.same_loc_r = 2'h1;
            st_nxt.last_loc_r = st_r.sys_cnt_r;

            // aligned capture resets dividers and read pointers
            if (ref_align_enable && !st_r.map_r[ref_cfg.pos_select])
            begin
                st_nxt.sys_cnt_r = '0;
                st_nxt.rptr_rst_r = 1'b1;
                if (st_r.sys_cnt_r != SYS_LAST)
                    alm_set[ALM_CLK_REALIGNED] = 1'b1;
            end
            // edge on a risky position raises alignment fault
            else if (ref_align_enable)
                alm_set[ALM_CLK_ALIGNMENT] = 1'b1;

            // trigger divider reset on reference edge
            // trigger realign even when alignment disabled
            if (st_nxt.same_loc_r == REALIGN_PULSES || ref_align_enable)
            begin
                if (st_r.trig_cnt_r != trig_last)
                    alm_set[ALM_TRIG_REALIGNED] = 1'b1;
                st_nxt.trig_cnt_r = '0;
                st_nxt.trig_clk_r = 1'b0;
                st_nxt.tone_pend_r = 1'b1;
            end
        end

        // ------------------------------------------------------------
        // alarms
        // ------------------------------------------------------------
        // write-one clear, set wins
        // clear pulse drops only bits not set again this cycle
        st_nxt.alm_r = (st_r.alm_r & ~fault_clear) | alm_set;

        // ------------------------------------------------------------
        // tone selection
        // ------------------------------------------------------------
        // tone sample on trigger clock rising
        if (st_nxt.trig_clk_r && !st_r.trig_clk_r)
            st_nxt.tone_s_r = tone_s;
        // both channels updated together after a trigger realignment and on each trigger clock rising
        if (st_r.tone_pend_r || (st_nxt.trig_clk_r && !st_r.trig_clk_r))
        begin
            st_nxt.tone_a_r = st_r.tone_s_r;
            st_nxt.tone_b_r = st_r.tone_s_r;
        end

        // ------------------------------------------------------------
        // registered outputs
        // ------------------------------------------------------------
        // output gated by both enables
        st_nxt.trig_out_r = st_nxt.trig_clk_r & trig_cfg.trigger_output_enable & trig_cfg.oscillator_run_enable;
        st_nxt.fault_r = |(st_nxt.alm_r & ~fault_mask_register);
        st_nxt.mute_r = mute_on_fault & (|st_nxt.alm_r);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            // edge bits of the map read one from reset
            st_r.map_r <= MAP_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign ref_position_map = st_r.map_r;
    assign system_fault_register = st_r.alm_r;
    assign fault_pin = st_r.fault_r;
    assign output_mute = st_r.mute_r;
    assign trigger_clock_out = st_r.trig_out_r;
    assign read_ptr_reset = st_r.rptr_rst_r;
    assign tone_ch_a = st_r.tone_a_r;
    assign tone_ch_b = st_r.tone_b_r;
endmodule : srw_sysref_window

// file: dv/srw_ref_source.sv
`timescale 1ns/1ps
module srw_ref_source
    import srw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic fire,
    input wire logic run,
    input wire logic [3:0] period_n,
    input wire logic [3:0] boundary,
    input wire logic clean,
    output logic ref_pulse_in,
    output logic [MAP_BITS-1:0] ref_phase_taps
);
    logic [7:0] per_cnt;
    logic [2:0] hi_cnt;
    logic go;
    assign go = fire || (run && per_cnt == 8'h00);
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            per_cnt <= 8'h00;
            hi_cnt <= 3'h0;
        end
        else
        begin
            // period n times eight
            // idle counter sits at zero so a run opens with a pulse
            per_cnt <= !run ? 8'h00 : ((per_cnt == 8'h00) ? 8'(SYS_DIV * period_n - 1) : per_cnt - 8'h01);
            hi_cnt <= go ? 3'h4 : ((hi_cnt != 3'h0) ? hi_cnt - 3'h1 : 3'h0);
        end
    end
    // first high cycle carries the edge position
    assign ref_pulse_in = hi_cnt != 3'h0;
    assign ref_phase_taps = !ref_pulse_in ? 16'h0000 : ((hi_cnt != 3'h4 || clean) ? 16'hFFFF : ~(16'hFFFF << boundary));
endmodule : srw_ref_source

// file: dv/srw_sysref_window_asserts.sv
`timescale 1ns/1ps
module srw_sysref_window_asserts
    import srw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ref_pulse_in,
    input wire srw_pkg::srw_ref_cfg_t ref_cfg,
    input wire srw_pkg::srw_trig_cfg_t trig_cfg,
    input wire logic [srw_pkg::ALM_W-1:0] fault_mask_register,
    input wire logic [srw_pkg::ALM_W-1:0] fault_clear,
    input wire logic mute_on_fault,
    input wire logic [srw_pkg::MAP_BITS-1:0] ref_position_map,
    input wire logic [srw_pkg::ALM_W-1:0] system_fault_register,
    input wire logic fault_pin,
    input wire logic output_mute,
    input wire logic trigger_clock_out,
    input wire logic read_ptr_reset,
    input wire srw_pkg::srw_tone_t tone_ch_a,
    input wire srw_pkg::srw_tone_t tone_ch_b
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic [ALM_W-1:0] keep;
    assign keep = system_fault_register & ~fault_clear;
    a_map_edges_one: assert property (ref_position_map[MAP_LO] && ref_position_map[MAP_HI])
        else $error("map edge bit cleared");
    a_pin_unmasked: assert property ($stable(fault_mask_register) && $stable(system_fault_register)
        |-> fault_pin == |(system_fault_register & ~fault_mask_register)) else $error("fault pin wrong");
    a_mute_follows: assert property ($stable(system_fault_register) && $stable(mute_on_fault)
        |-> output_mute == (mute_on_fault && system_fault_register != '0)) else $error("mute wrong");
    a_alarm_sticky: assert property (|keep |=> (system_fault_register & $past(keep)) == $past(keep))
        else $error("alarm lost");
    a_rdptr_single: assert property (read_ptr_reset |=> !read_ptr_reset)
        else $error("read pointer reset too long");
    a_rdptr_cause: assert property (read_ptr_reset |-> $past(ref_pulse_in, 2) || $past(ref_pulse_in, 3))
        else $error("read pointer reset without pulse");
    a_edge_refused: assert property ((!ref_cfg.ref_processing_enable || ref_cfg.ref_receiver_sleep) [*5]
        |=> !read_ptr_reset) else $error("edge taken while disabled");
    a_trig_gated: assert property (!(trig_cfg.trigger_output_enable && trig_cfg.oscillator_run_enable) [*4]
        |-> !trigger_clock_out) else $error("trigger clock not gated");
    a_realign_cause: assert property ($rose(system_fault_register[ALM_CLK_REALIGNED])
        |-> read_ptr_reset || $past(read_ptr_reset)) else $error("realign flag without edge");
    a_tone_match: assert property (tone_ch_a == tone_ch_b)
        else $error("channel tones differ");
    a_trig_realign_cause: assert property ($rose(system_fault_register[ALM_TRIG_REALIGNED])
        |-> $past(ref_pulse_in, 2) || $past(ref_pulse_in, 3)) else $error("trigger realign without pulse");
endmodule : srw_sysref_window_asserts

bind srw_sysref_window srw_sysref_window_asserts srw_sysref_window_asserts_inst (
    .clk(clk), .reset(reset), .ref_pulse_in(ref_pulse_in), .ref_cfg(ref_cfg), .trig_cfg(trig_cfg),
    .fault_mask_register(fault_mask_register), .fault_clear(fault_clear), .mute_on_fault(mute_on_fault),
    .ref_position_map(ref_position_map), .system_fault_register(system_fault_register),
    .fault_pin(fault_pin), .output_mute(output_mute), .trigger_clock_out(trigger_clock_out),
    .read_ptr_reset(read_ptr_reset), .tone_ch_a(tone_ch_a), .tone_ch_b(tone_ch_b)
);

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import srw_pkg::*;
    logic clk, reset, fire, run, clean, ref_pulse_in, ref_align_enable, mute_on_fault, use_lsb_strobe, trg_q;
    logic fault_pin, output_mute, trigger_clock_out, read_ptr_reset;
    logic [3:0] period_n, boundary, input_width, b1, b2, bus_strobe_input, bus_strobe_seen, seen_acc;
    logic [MAP_BITS-1:0] ref_phase_taps, ref_position_map;
    srw_ref_cfg_t ref_cfg;
    srw_trig_cfg_t trig_cfg;
    srw_tone_t tone_pins, tone_ch_a, tone_ch_b;
    logic [ALM_W-1:0] fault_mask_register, fault_clear, system_fault_register;
    logic [NUM_BUSES*12-1:0] bus_data;
    logic [NUM_BUSES*WPTR_W-1:0] bus_write_ptr;
    logic [15:0] rp_cnt, tog, t0, cyc;
    logic [7:0] rnd;
    int fail_count, checks;
    srw_ref_source srw_ref_source_inst (.clk(clk), .reset(reset), .fire(fire), .run(run), .period_n(period_n),
        .boundary(boundary), .clean(clean), .ref_pulse_in(ref_pulse_in), .ref_phase_taps(ref_phase_taps));
    srw_sysref_window #(.DATA_W(12)) srw_sysref_window_inst (.clk(clk), .reset(reset),
        .ref_pulse_in(ref_pulse_in), .ref_phase_taps(ref_phase_taps), .ref_cfg(ref_cfg), .trig_cfg(trig_cfg),
        .ref_align_enable(ref_align_enable), .fault_mask_register(fault_mask_register), .fault_clear(fault_clear),
        .mute_on_fault(mute_on_fault), .tone_pins(tone_pins), .use_lsb_strobe(use_lsb_strobe),
        .input_width(input_width), .bus_strobe_input(bus_strobe_input), .bus_data(bus_data),
        .ref_position_map(ref_position_map), .system_fault_register(system_fault_register), .fault_pin(fault_pin),
        .output_mute(output_mute), .trigger_clock_out(trigger_clock_out), .read_ptr_reset(read_ptr_reset),
        .tone_ch_a(tone_ch_a), .tone_ch_b(tone_ch_b), .bus_strobe_seen(bus_strobe_seen),
        .bus_write_ptr(bus_write_ptr));
    // ----
    // helpers
    // ----
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    function automatic logic near(input logic [15:0] m, input logic [3:0] b);
        return |(m & ((16'h000F << b) >> 2));
    endfunction : near
    function automatic logic [15:0] exp_map(input logic [3:0] b, input logic fine);
        return 16'h8001 | (16'h0001 << b) | (fine ? 16'h0000 : (16'h0002 << b));
    endfunction : exp_map
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic shot(input logic [3:0] b, input logic c);
        @(posedge clk);
        boundary <= b;
        clean <= c;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        tick(12);
    endtask : shot
    task automatic clear_all();
        fault_clear <= 3'h7;
        @(posedge clk);
        fault_clear <= 3'h0;
    endtask : clear_all
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 16'h0001;
        trg_q <= trigger_clock_out;
        seen_acc <= seen_acc | bus_strobe_seen;
        if (read_ptr_reset) rp_cnt <= rp_cnt + 16'h0001;
        if (trigger_clock_out !== trg_q) tog <= tog + 16'h0001;
        if (cyc == 16'h07D0)
        begin
            fail_count++;
            final_report();
        end
    end
    initial
    begin
        {reset, ref_cfg, trig_cfg} = '1;
        {fire, run, clean, ref_align_enable, mute_on_fault, use_lsb_strobe, trg_q} = '0;
        {period_n, boundary, input_width, bus_strobe_input, seen_acc, bus_data} = '0;
        {fault_mask_register, fault_clear, tone_pins, rp_cnt, tog, cyc} = '0;
        ref_cfg = '0;
        trig_cfg = '0;
        rnd = 8'h21;
        tick(2);
        reset <= 1'b0;
        tick(2);
        cmp(ref_position_map, 16'h8001, "reset map");
        shot(4'h0, 1'b1);
        cmp(rp_cnt, 16'h0000, "edge refused");
        ref_cfg.ref_step_fine <= 1'b1;
        ref_cfg.pos_select <= 4'hE;
        @(posedge clk);
        ref_cfg.ref_processing_enable <= 1'b1;
        ref_align_enable <= 1'b1;
        shot(4'h0, 1'b1);
        cmp(rp_cnt, 16'h0001, "edge taken");
        cmp(ref_position_map, 16'h8001, "clean map");
        cmp(16'(system_fault_register[ALM_CLK_ALIGNMENT]), 16'h0000, "valid position");
        $display("test basic done");
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            b1 = 4'h3 + 4'(rnd % 8'h03);
            rnd = lfsr(rnd);
            b2 = 4'hA + 4'(rnd % 8'h03);
            ref_cfg.ref_step_fine <= k[0];
            ref_cfg.ref_map_persistence <= 1'b0;
            @(posedge clk);
            ref_cfg.ref_map_persistence <= k[1];
            shot(b1, 1'b0);
            shot(b2, 1'b0);
            cmp(16'(near(ref_position_map, b2)), 16'h0001, "latest edge");
            cmp(ref_position_map, exp_map(b2, k[0]) | (k[1] ? exp_map(b1, k[0]) : 16'h0000), "zoom map");
            cmp(16'(near(ref_position_map, b1)), 16'(k[1]), "persistence");
            $display("test map %0d done", k);
        end
        clear_all();
        ref_cfg.pos_select <= 4'h0;
        mute_on_fault <= 1'b1;
        shot(4'h0, 1'b1);
        tick(20);
        cmp(16'({fault_pin, output_mute, system_fault_register[ALM_CLK_ALIGNMENT]}), 16'h0007, "sticky");
        fault_mask_register <= 3'h7;
        tick(3);
        cmp(16'({fault_pin, output_mute}), 16'h0001, "masked pin");
        clear_all();
        tick(3);
        cmp(16'({output_mute, system_fault_register}), 16'h0000, "cleared");
        $display("test alarms done");
        ref_cfg.pos_select <= 4'hE;
        ref_align_enable <= 1'b1;
        period_n <= 4'h2;
        run <= 1'b1;
        trig_cfg <= {8'h04, 2'h3};
        tick(80);
        t0 = tog;
        tick(64);
        cmp(16'(tog != t0), 16'h0001, "trigger runs");
        rnd = lfsr(rnd);
        trig_cfg.trigger_output_enable <= 1'b0;
        tone_pins <= rnd[4:0];
        clear_all();
        tick(4);
        t0 = tog;
        tick(64);
        cmp(tog - t0, 16'h0000, "trigger gated");
        cmp(16'(tone_ch_a), 16'(rnd[4:0]), "tone a");
        cmp(16'(tone_ch_b), 16'(rnd[4:0]), "tone b");
        cmp(16'(system_fault_register[ALM_TRIG_REALIGNED]), 16'h0000, "steady trigger");
        ref_cfg.ref_processing_enable <= 1'b0;
        @(posedge clk);
        run <= 1'b0;
        $display("test trigger done");
        bus_strobe_input <= 4'h1;
        @(posedge clk);
        bus_strobe_input <= 4'h0;
        use_lsb_strobe <= 1'b1;
        input_width <= 4'hA;
        tick(4);
        bus_data[14] <= 1'b1;
        @(posedge clk);
        bus_data[14] <= 1'b0;
        tick(8);
        cmp(16'(seen_acc), 16'h0003, "strobes");
        cmp(16'(bus_write_ptr[7:0]), 16'h007C, "write pointers");
        $display("test strobe done");
        final_report();
    end
endmodule : tb
